// ===== rhs_pkg.sv
// package: root hub mask/removable and hub status register layout
package rhs_pkg;
   localparam int          RHS_NPORT           = 15;
   localparam logic [7:0]  RHS_OFS_MASK_REM    = 8'h4C;
   localparam logic [7:0]  RHS_OFS_STATUS      = 8'h50;
   localparam int          RHS_MASK_LSB        = 16;
   localparam int          RHS_REM_LSB         = 0;
   localparam int          RHS_BIT_WAKE_CLR    = 31;
   localparam int          RHS_BIT_OC_CHANGE   = 17;
   localparam int          RHS_BIT_PWR_ON      = 16;
   localparam int          RHS_BIT_WAKE_EN     = 15;
   localparam int          RHS_BIT_OC_FLAG     = 1;
   localparam int          RHS_BIT_PWR_OFF     = 0;
   localparam logic [15:0] RHS_MASK_RESET      = 16'h0000;
   localparam logic [15:0] RHS_REM_RESET       = 16'h0000;
   localparam logic [15:0] RHS_RSVD_BIT0_CLR   = 16'hFFFE;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } rhs_req_s;

   typedef struct packed {
      logic [15:0] port_power_mask;
      logic [15:0] removable_flags;
      logic        wake_enable;
      logic        overcurrent_change;
      logic        oc_prev;
      logic [15:0] port_power;
      logic [31:0] rdata;
      logic        resume_pulse;
   } rhs_state_s;
endpackage : rhs_pkg

// ===== rhs_regs.sv
// module: root hub port mask/removable register and hub status register
//
// Operation
// - mask/removable register answers at byte offset 4Ch.
// - bits 31..16 hold port power mask; set bit means per-port control only.
// - cleared mask bit: port follows only global power on/off commands.
// - mask ignored when switching_select is 0 (global mode).
// - mask bit 0 reserved; bit n maps to downstream port n.
// - bits 15..0 removable flags; 0 removable, 1 non-removable.
// - removable flag bit 0 reserved; bit n describes port n.
// - hub status register answers at byte offset 50h.
// - hub status in lower half, status change bits in upper half.
// - overcurrent change sets on indicator change; write 1 clears.
// - global power on: all ports, or unmasked ports in per-port mode; reads 0.
// - global power off: all ports, or unmasked ports in per-port mode; reads 0.
// - with wake enable, connect change while suspended signals resume.
`timescale 1ns/1ns
module rhs_regs
   import rhs_pkg::*;
(
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire rhs_pkg::rhs_req_s req,
   output logic [31:0]           rdata,
   input  wire logic             switching_select,
   input  wire logic             overcurrent_in,
   input  wire logic [15:0]      port_power_on_req,
   input  wire logic [15:0]      port_power_off_req,
   input  wire logic             suspended,
   input  wire logic             connect_change,
   output logic [15:0]           port_power,
   output logic [15:0]           port_power_mask,
   output logic [15:0]           removable_flags,
   output logic                  resume_detect
);
   import rhs_pkg::*;

   rhs_state_s st_ff;
   rhs_state_s nxt_st;

   // a port takes the global command when in global mode or when unmasked
   function automatic logic [15:0] rhs_global_sel(input logic sel, input logic [15:0] mask);
      rhs_global_sel = sel ? ~mask : 16'hFFFF;
   endfunction : rhs_global_sel

   logic        wr_mask;
   logic        wr_stat;
   logic [15:0] gsel;

   always_comb begin
      wr_mask = req.wr && (req.addr == RHS_OFS_MASK_REM);
      wr_stat = req.wr && (req.addr == RHS_OFS_STATUS);
      gsel    = rhs_global_sel(switching_select, st_ff.port_power_mask);
      nxt_st  = st_ff;
      nxt_st.resume_pulse = 1'b0;
      if (wr_mask) begin
         // reserved bit 0 of both fields kept at zero
         nxt_st.port_power_mask = req.wdata[RHS_MASK_LSB +: 16] & RHS_RSVD_BIT0_CLR;
         nxt_st.removable_flags = req.wdata[RHS_REM_LSB +: 16] & RHS_RSVD_BIT0_CLR;
      end
      // per-port commands act only on masked ports in per-port mode
      nxt_st.port_power = (st_ff.port_power | (port_power_on_req & ~gsel))
                          & ~(port_power_off_req & ~gsel);
      if (wr_stat && req.wdata[RHS_BIT_PWR_ON])
         nxt_st.port_power = nxt_st.port_power | (gsel & RHS_RSVD_BIT0_CLR);
      if (wr_stat && req.wdata[RHS_BIT_PWR_OFF])
         nxt_st.port_power = nxt_st.port_power & ~gsel;
      if (wr_stat && req.wdata[RHS_BIT_WAKE_EN])
         nxt_st.wake_enable = 1'b1;
      if (wr_stat && req.wdata[RHS_BIT_WAKE_CLR])
         nxt_st.wake_enable = 1'b0;
      nxt_st.oc_prev = overcurrent_in;
      // set wins over a same-cycle clear so no change is lost
      if (wr_stat && req.wdata[RHS_BIT_OC_CHANGE])
         nxt_st.overcurrent_change = 1'b0;
      if (overcurrent_in != st_ff.oc_prev)
         nxt_st.overcurrent_change = 1'b1;
      nxt_st.resume_pulse = st_ff.wake_enable && suspended && connect_change;
      nxt_st.rdata = 32'h0000_0000;
      if (req.rd && req.addr == RHS_OFS_MASK_REM)
         nxt_st.rdata = {st_ff.port_power_mask, st_ff.removable_flags};
      else if (req.rd && req.addr == RHS_OFS_STATUS) begin
         // command bits 31,16,0 read zero; change bits sit in the upper half
         nxt_st.rdata[RHS_BIT_OC_CHANGE] = st_ff.overcurrent_change;
         nxt_st.rdata[RHS_BIT_WAKE_EN]   = st_ff.wake_enable;
         nxt_st.rdata[RHS_BIT_OC_FLAG]   = st_ff.oc_prev;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_ff.port_power_mask    <= RHS_MASK_RESET;
         st_ff.removable_flags    <= RHS_REM_RESET;
         st_ff.wake_enable        <= 1'b0;
         st_ff.overcurrent_change <= 1'b0;
         st_ff.oc_prev            <= 1'b0;
         st_ff.port_power         <= 16'h0000;
         st_ff.rdata              <= 32'h0000_0000;
         st_ff.resume_pulse       <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata           = st_ff.rdata;
   assign port_power      = st_ff.port_power;
   assign port_power_mask = st_ff.port_power_mask;
   assign removable_flags = st_ff.removable_flags;
   assign resume_detect   = st_ff.resume_pulse;

   property p_oc_set;
      @(posedge ref_clk) disable iff (srst)
      (overcurrent_in != $past(overcurrent_in)) |=> st_ff.overcurrent_change;
   endproperty
   a_oc_set: assert property (p_oc_set) else $error("overcurrent change not set");

   property p_oc_clr;
      @(posedge ref_clk) disable iff (srst)
      (wr_stat && req.wdata[RHS_BIT_OC_CHANGE] && overcurrent_in == st_ff.oc_prev)
      |=> !st_ff.overcurrent_change;
   endproperty
   a_oc_clr: assert property (p_oc_clr) else $error("overcurrent change not cleared");

   property p_pwr_on_global;
      @(posedge ref_clk) disable iff (srst)
      (wr_stat && req.wdata[RHS_BIT_PWR_ON] && !req.wdata[RHS_BIT_PWR_OFF] && !switching_select)
      |=> port_power == RHS_RSVD_BIT0_CLR;
   endproperty
   a_pwr_on_global: assert property (p_pwr_on_global) else $error("global on failed");

   property p_pwr_off_global;
      @(posedge ref_clk) disable iff (srst)
      (wr_stat && req.wdata[RHS_BIT_PWR_OFF] && !switching_select) |=> port_power == 16'h0000;
   endproperty
   a_pwr_off_global: assert property (p_pwr_off_global) else $error("global off failed");

   property p_masked_keep;
      @(posedge ref_clk) disable iff (srst)
      (wr_stat && switching_select && port_power_on_req == 16'h0000
       && port_power_off_req == 16'h0000)
      |=> ((port_power ^ $past(port_power)) & $past(st_ff.port_power_mask)) == 16'h0000;
   endproperty
   a_masked_keep: assert property (p_masked_keep) else $error("masked port changed");

   property p_rsvd_bit0;
      @(posedge ref_clk) disable iff (srst)
      1'b1 |-> !port_power_mask[0] && !removable_flags[0];
   endproperty
   a_rsvd_bit0: assert property (p_rsvd_bit0) else $error("reserved bit 0 set");

   property p_cmd_read_zero;
      @(posedge ref_clk) disable iff (srst)
      (req.rd && req.addr == RHS_OFS_STATUS)
      |=> !rdata[RHS_BIT_PWR_ON] && !rdata[RHS_BIT_PWR_OFF] && !rdata[RHS_BIT_WAKE_CLR];
   endproperty
   a_cmd_read_zero: assert property (p_cmd_read_zero) else $error("command bit read 1");

   property p_resume;
      @(posedge ref_clk) disable iff (srst)
      (st_ff.wake_enable && suspended && connect_change) |=> resume_detect ##1 !resume_detect[*1];
   endproperty
   a_resume: assert property (p_resume) else $error("resume not signalled");

   property p_mask_read;
      @(posedge ref_clk) disable iff (srst)
      (req.rd && req.addr == RHS_OFS_MASK_REM && !wr_mask)
      |=> rdata == {port_power_mask, removable_flags};
   endproperty
   a_mask_read: assert property (p_mask_read) else $error("mask read mismatch");

   property p_wake_set;
      @(posedge ref_clk) disable iff (srst)
      (wr_stat && req.wdata[RHS_BIT_WAKE_EN] && !req.wdata[RHS_BIT_WAKE_CLR])
      |=> st_ff.wake_enable;
   endproperty
   a_wake_set: assert property (p_wake_set) else $error("wake enable not set");

   property p_wake_clr;
      @(posedge ref_clk) disable iff (srst)
      (wr_stat && req.wdata[RHS_BIT_WAKE_CLR]) |=> !st_ff.wake_enable;
   endproperty
   a_wake_clr: assert property (p_wake_clr) else $error("wake not cleared");

   property p_no_resume;
      @(posedge ref_clk) disable iff (srst)
      !(st_ff.wake_enable && suspended && connect_change) |=> !resume_detect;
   endproperty
   a_no_resume: assert property (p_no_resume) else $error("stray resume");

   // a steady indicator leaves the change flag alone unless software clears it
   property p_oc_hold;
      @(posedge ref_clk) disable iff (srst)
      (overcurrent_in == st_ff.oc_prev && !(wr_stat && req.wdata[RHS_BIT_OC_CHANGE]))
      |=> st_ff.overcurrent_change == $past(st_ff.overcurrent_change);
   endproperty
   a_oc_hold: assert property (p_oc_hold) else $error("overcurrent change moved");

   property p_status_read;
      @(posedge ref_clk) disable iff (srst)
      (req.rd && req.addr == RHS_OFS_STATUS)
      |=> rdata[RHS_BIT_OC_CHANGE] == $past(st_ff.overcurrent_change)
          && rdata[RHS_BIT_WAKE_EN] == $past(st_ff.wake_enable);
   endproperty
   a_status_read: assert property (p_status_read) else $error("status bits wrong");

   // per-port commands carry no weight while switching is global
   property p_global_hold;
      @(posedge ref_clk) disable iff (srst)
      (!switching_select && !wr_stat) |=> port_power == $past(port_power);
   endproperty
   a_global_hold: assert property (p_global_hold) else $error("global power moved");

   property p_unmasked_hold;
      @(posedge ref_clk) disable iff (srst)
      (switching_select && !wr_stat)
      |=> ((port_power ^ $past(port_power)) & ~$past(st_ff.port_power_mask)) == 16'h0000;
   endproperty
   a_unmasked_hold: assert property (p_unmasked_hold) else $error("unmasked moved");

   // partial decode would let a neighbour offset alias onto these registers
   property p_unmapped_wr;
      @(posedge ref_clk) disable iff (srst)
      (req.wr && req.addr != RHS_OFS_MASK_REM && req.addr != RHS_OFS_STATUS)
      |=> port_power_mask == $past(port_power_mask)
          && removable_flags == $past(removable_flags)
          && st_ff.wake_enable == $past(st_ff.wake_enable);
   endproperty
   a_unmapped_wr: assert property (p_unmapped_wr) else $error("stray write");

   c_oc: cover property (@(posedge ref_clk) disable iff (srst) st_ff.overcurrent_change);
   c_resume: cover property (@(posedge ref_clk) disable iff (srst) resume_detect);
   c_perport: cover property (@(posedge ref_clk) disable iff (srst)
                              wr_stat && switching_select && req.wdata[RHS_BIT_PWR_ON]);
   c_wake_clr: cover property (@(posedge ref_clk) disable iff (srst)
                               wr_stat && req.wdata[RHS_BIT_WAKE_CLR]);
   c_on_off: cover property (@(posedge ref_clk) disable iff (srst)
                             wr_stat && req.wdata[RHS_BIT_PWR_ON] && req.wdata[RHS_BIT_PWR_OFF]);
endmodule : rhs_regs

// ===== rhs_regs_test.sv
// testbench: register access, power switching and status events of rhs_regs
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s exp %h got %h", nm, e, g); end end
module rhs_regs_test;
   import rhs_pkg::*;
   logic        ref_clk = 0, srst = 1, sw_sel = 0, oc_in = 0, susp = 0, conn = 0;
   rhs_req_s    req = '0;
   logic [15:0] on_req = '0, off_req = '0, port_power, mask, rem;
   logic [31:0] rdata;
   logic        resume_detect;
   int          error_cnt = 0, n_tests = 0;
   always #4 ref_clk = ~ref_clk;
   rhs_regs dut (.ref_clk(ref_clk), .srst(srst), .req(req), .rdata(rdata),
      .switching_select(sw_sel), .overcurrent_in(oc_in), .port_power_on_req(on_req),
      .port_power_off_req(off_req), .suspended(susp), .connect_change(conn),
      .port_power(port_power), .port_power_mask(mask), .removable_flags(rem),
      .resume_detect(resume_detect));
   // every task starts and ends 1 ns after a rising edge, with an idle cycle at the end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      req.wr = 1; req.addr = a; req.wdata = d;
      @(posedge ref_clk); #1;
      req = '0;
      @(posedge ref_clk); #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      req.rd = 1; req.addr = a;
      @(posedge ref_clk); #1;
      `CHK("rdata", e, rdata)
      req = '0;
      @(posedge ref_clk); #1;
   endtask : rd
   task automatic pp(input logic [15:0] on, input logic [15:0] off, input logic [15:0] e);
      on_req = on; off_req = off;
      @(posedge ref_clk); #1;
      on_req = '0; off_req = '0;
      @(posedge ref_clk); #1;
      `CHK("port_power", e, port_power)
   endtask : pp
   // resume is a one-cycle pulse, so it is collected over a short window
   task automatic conn_evt(input logic e);
      logic seen = 0;
      conn = 1;
      repeat (4) begin
         @(posedge ref_clk); #1;
         conn = 0;
         seen = seen | resume_detect;
      end
      `CHK("resume_detect", e, seen)
   endtask : conn_evt
   task automatic t_reset;
      rd(RHS_OFS_MASK_REM, 32'h0000_0000);
      rd(RHS_OFS_STATUS, 32'h0000_0000);
      `CHK("port_power", 16'h0000, port_power)
   endtask : t_reset
   task automatic t_mask;
      wr(RHS_OFS_MASK_REM, 32'hFFFF_FFFF);
      `CHK("port_power_mask", 16'hFFFE, mask)
      `CHK("removable_flags", 16'hFFFE, rem)
      rd(RHS_OFS_MASK_REM, 32'hFFFE_FFFE);
      wr(8'h54, 32'h0000_0000);
      rd(RHS_OFS_MASK_REM, 32'hFFFE_FFFE);
      rd(8'h48, 32'h0000_0000);
      wr(RHS_OFS_MASK_REM, 32'h00F0_1234);
      rd(RHS_OFS_MASK_REM, 32'h00F0_1234);
   endtask : t_mask
   task automatic t_global;
      wr(RHS_OFS_STATUS, 32'h0001_0000);
      `CHK("port_power", 16'hFFFE, port_power)
      rd(RHS_OFS_STATUS, 32'h0000_0000);
      pp(16'h0000, 16'h0F00, 16'hFFFE);
      wr(RHS_OFS_STATUS, 32'h0000_0001);
      `CHK("port_power", 16'h0000, port_power)
      wr(RHS_OFS_STATUS, 32'h0001_0001);
      `CHK("port_power", 16'h0000, port_power)
   endtask : t_global
   task automatic t_perport;
      sw_sel = 1;
      wr(RHS_OFS_STATUS, 32'h0001_0000);
      `CHK("port_power", 16'hFF0E, port_power)
      pp(16'h0030, 16'h0000, 16'hFF3E);
      pp(16'h0100, 16'h0000, 16'hFF3E);
      wr(RHS_OFS_STATUS, 32'h0000_0001);
      `CHK("port_power", 16'h0030, port_power)
      pp(16'h0000, 16'h0010, 16'h0020);
   endtask : t_perport
   task automatic t_wake;
      susp = 1;
      conn_evt(1'b0);
      wr(RHS_OFS_STATUS, 32'h0000_8000);
      rd(RHS_OFS_STATUS, 32'h0000_8000);
      conn_evt(1'b1);
      susp = 0;
      conn_evt(1'b0);
      susp = 1;
      wr(RHS_OFS_STATUS, 32'h8000_8000);
      rd(RHS_OFS_STATUS, 32'h0000_0000);
      conn_evt(1'b0);
   endtask : t_wake
   task automatic t_oc;
      oc_in = 1;
      repeat (3) @(posedge ref_clk);
      #1;
      rd(RHS_OFS_STATUS, 32'h0002_0002);
      wr(RHS_OFS_STATUS, 32'h0000_0000);
      rd(RHS_OFS_STATUS, 32'h0002_0002);
      wr(RHS_OFS_STATUS, 32'h0002_0000);
      rd(RHS_OFS_STATUS, 32'h0000_0002);
      // falling indicator in the same cycle as a clear: the new change survives
      oc_in = 0;
      wr(RHS_OFS_STATUS, 32'h0002_0000);
      rd(RHS_OFS_STATUS, 32'h0002_0000);
      wr(RHS_OFS_STATUS, 32'h0002_0000);
      rd(RHS_OFS_STATUS, 32'h0000_0000);
   endtask : t_oc
   // reset in mid-run, with fields and port power still set from earlier scenarios
   task automatic t_rerun;
      srst = 1;
      repeat (2) @(posedge ref_clk);
      #1;
      srst = 0;
      t_reset();
   endtask : t_rerun
   task automatic stop_test;
      if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : stop_test
   // a hang anywhere is cut short and counted as a mismatch
   initial begin
      #200000;
      error_cnt++;
      stop_test();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      #1;
      srst = 0;
      t_reset();
      t_mask();
      t_global();
      t_perport();
      t_wake();
      t_oc();
      t_rerun();
      stop_test();
   end
endmodule : rhs_regs_test
